// ===== sec_pkg.sv
// Holds the shared constants and types of the security status and scheme-select block.
// Assumes a single core clock domain; the serial link pins are sampled by that clock.
package sec_pkg;

  // ----------------------------------------------------------------
  // Security status register layout
  // ----------------------------------------------------------------
  localparam int unsigned SR_WIDTH      = 8;
  localparam int unsigned BIT_SCHEME    = 7;
  localparam int unsigned BIT_E_FAIL    = 6;
  localparam int unsigned BIT_P_FAIL    = 5;
  localparam int unsigned BIT_RESERVED  = 4;
  localparam int unsigned BIT_E_SUSP    = 3;
  localparam int unsigned BIT_P_SUSP    = 2;
  localparam int unsigned BIT_LOCKDOWN  = 1;
  localparam int unsigned BIT_FACTORY   = 0;
  localparam logic        RESERVED_VAL  = 1'b0;
  localparam logic        FLAG_RESET    = 1'b0;

  // ----------------------------------------------------------------
  // Serial framing
  // ----------------------------------------------------------------
  localparam logic [2:0] BIT_FIRST  = 3'h0;
  localparam logic [2:0] BIT_LAST   = 3'h7;
  localparam logic [1:0] BYTES_NONE = 2'h0;
  localparam logic [1:0] BYTES_ONE  = 2'h1;
  localparam logic [1:0] BYTES_SAT  = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_OPCODE = 2'b01,
    ST_READ   = 2'b10
  } link_state_t;

  // Completion report of one erase or program from the array sequencer
  typedef struct packed {
    logic done;
    logic is_erase;
    logic fail;
    logic protected_hit;
  } op_result_t;

  // One-cycle suspend and resume pulses from the array sequencer
  typedef struct packed {
    logic erase_suspend;
    logic erase_resume;
    logic program_suspend;
    logic program_resume;
  } suspend_evt_t;

  // Protection verdict handed to the array sequencer
  typedef struct packed {
    logic block_enable;
    logic sector_enable;
    logic level_locked;
    logic all_locked;
    logic array_deny;
    logic otp_write_locked;
  } protect_t;

endpackage

// ===== security_status_protect.sv
// Holds the security status register, its serial read and write commands, and the
// protection scheme selection that steers the array write protection.
// Assumes the array sequencer runs on clk, the serial link pins come from outside and
// the non-volatile copies of the one-time bits are kept by the surrounding core.
//
// Summary of operation
// - Erase failure flag set by failed erase, cleared by any clean completion
// - Program failure flag: fail or protected target
// - Failure flags only report, never stop operations
// - Erase suspended flag set on suspend, cleared resume
// - Program suspended flag set on suspend, cleared resume
// - Factory lock indicator is read only
// - Write command sets customer lockdown, then frozen
// - Secured one-time mode denies main array access
// - Scheme flag: 0 block-level, 1 per-sector, default 0
// - Scheme flag never returns to zero
// - Exactly one protection scheme active
// - Per-sector mode powers up fully locked until unlock
// - Block levels frozen by status lock and low pin
// - Scheme command sets bit seven, enabling sector commands
// - Per-sector mode: low protect pin locks everything
// - Register readable anytime, repeatedly within one frame
`timescale 1ns/100ps

module security_status_protect #(
  parameter logic [7:0] WRITE_ENABLE_OP  = 8'hA1,
  parameter logic [7:0] SEC_READ_OP      = 8'hA2,
  parameter logic [7:0] SEC_WRITE_OP     = 8'hA3,
  parameter logic [7:0] SCHEME_SELECT_OP = 8'hA4,
  parameter logic [7:0] GLOBAL_UNLOCK_OP = 8'hA5
) (
  // Core clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Serial link pins
  input  wire logic                  sclk,
  input  wire logic                  cs_n,
  input  wire logic                  si,
  input  wire logic                  wp_n,
  output logic                       so_out,
  output logic                       so_oe,
  // Array sequencer
  input  wire sec_pkg::op_result_t   op_result,
  input  wire sec_pkg::suspend_evt_t suspend_evt,
  input  wire logic                  otp_mode,
  input  wire logic                  status_write_disable,
  // Non-volatile copies, caught after reset release
  input  wire logic                  factory_lock,
  input  wire logic                  nv_scheme_select,
  input  wire logic                  nv_customer_lockdown,
  // Status and protection outputs
  output logic [7:0]                 security_status_register,
  output logic                       write_enable_latch,
  output sec_pkg::protect_t          protect
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic sclk_s1, sclk_s2, sclk_d;
  logic cs_n_s1, cs_n_s2, cs_n_d;
  logic si_s1,   si_s2;
  logic wp_n_s1, wp_n_s2;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_d  <= 1'b0;
      cs_n_s1 <= 1'b1;
      cs_n_s2 <= 1'b1;
      cs_n_d  <= 1'b1;
      si_s1   <= 1'b0;
      si_s2   <= 1'b0;
      wp_n_s1 <= 1'b1;
      wp_n_s2 <= 1'b1;
    end else begin
      sclk_s1 <= sclk;
      sclk_s2 <= sclk_s1;
      sclk_d  <= sclk_s2;
      cs_n_s1 <= cs_n;
      cs_n_s2 <= cs_n_s1;
      cs_n_d  <= cs_n_s2;
      si_s1   <= si;
      si_s2   <= si_s1;
      wp_n_s1 <= wp_n;
      wp_n_s2 <= wp_n_s1;
    end
  end

  wire sclk_rise   = sclk_s2 & ~sclk_d;
  wire sclk_fall   = ~sclk_s2 & sclk_d;
  wire frame_start = ~cs_n_s2 & cs_n_d;
  wire frame_end   = cs_n_s2 & ~cs_n_d;
  wire in_frame    = ~cs_n_s2;

  // ----------------------------------------------------------------
  // Opcode capture
  // ----------------------------------------------------------------
  sec_pkg::link_state_t state, next_state;
  logic [2:0] bit_cnt;
  logic [1:0] byte_cnt;
  logic [7:0] shift_in;
  logic [7:0] opcode;
  logic [7:0] tx_byte;
  logic [2:0] tx_cnt;

  wire [7:0] next_shift = {shift_in[6:0], si_s2};
  wire       byte_done  = in_frame & sclk_rise & (bit_cnt == sec_pkg::BIT_LAST);
  wire       first_byte = byte_done & (state == sec_pkg::ST_OPCODE)
                          & (byte_cnt == sec_pkg::BYTES_NONE);
  wire       is_read    = next_shift == SEC_READ_OP;

  // Frame ends cleanly after exactly one opcode byte and nothing more
  wire cmd_ok = frame_end & (state == sec_pkg::ST_OPCODE)
                & (bit_cnt == sec_pkg::BIT_FIRST) & (byte_cnt == sec_pkg::BYTES_ONE);

  wire do_write_enable_cmd     = cmd_ok & (opcode == WRITE_ENABLE_OP);
  wire do_sec_wr   = cmd_ok & (opcode == SEC_WRITE_OP) & write_enable_latch;
  wire do_scheme   = cmd_ok & (opcode == SCHEME_SELECT_OP) & write_enable_latch;
  wire do_unlock   = cmd_ok & (opcode == GLOBAL_UNLOCK_OP) & write_enable_latch;
  wire write_taken = do_sec_wr | do_scheme | do_unlock;

  always_comb begin
    next_state = state;
    if (!in_frame) begin
      next_state = sec_pkg::ST_IDLE;
    end else if (frame_start) begin
      next_state = sec_pkg::ST_OPCODE;
    end else if (first_byte && is_read) begin
      next_state = sec_pkg::ST_READ;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state    <= sec_pkg::ST_IDLE;
      bit_cnt  <= sec_pkg::BIT_FIRST;
      byte_cnt <= sec_pkg::BYTES_NONE;
      shift_in <= 8'h00;
      opcode   <= 8'h00;
    end else begin
      state <= next_state;
      if (frame_start) begin
        bit_cnt  <= sec_pkg::BIT_FIRST;
        byte_cnt <= sec_pkg::BYTES_NONE;
      end else if (in_frame && sclk_rise) begin
        shift_in <= next_shift;
        bit_cnt  <= bit_cnt + 3'h1;
        if (byte_done && byte_cnt != sec_pkg::BYTES_SAT) begin
          byte_cnt <= byte_cnt + 2'h1;
        end
      end
      if (first_byte) begin
        opcode <= next_shift;
      end
    end
  end

  // ----------------------------------------------------------------
  // Security status bits
  // ----------------------------------------------------------------
  logic scheme_select, erase_fail, program_fail;
  logic erase_suspended_flag, program_suspended_flag;
  logic otp_customer_lockdown_flag, factory_locked, nv_loaded;
  logic volatile_all_locked;

  wire [7:0] status_now = {scheme_select, erase_fail, program_fail,
                           sec_pkg::RESERVED_VAL, erase_suspended_flag,
                           program_suspended_flag, otp_customer_lockdown_flag,
                           factory_locked};

  wire op_done  = op_result.done;
  wire op_erase = op_result.is_erase;
  wire op_bad   = op_result.fail;
  wire prog_bad = op_result.fail | op_result.protected_hit;

  // Failure flags are plain outputs of this block; nothing here feeds them back
  // into the sequencer, so a failure never stalls an operation.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      erase_fail   <= sec_pkg::FLAG_RESET;
      program_fail <= sec_pkg::FLAG_RESET;
    end else if (op_done) begin
      if (op_erase && op_bad) begin
        erase_fail <= 1'b1;
      end else if (!op_erase && prog_bad) begin
        program_fail <= 1'b1;
      end else begin
        erase_fail   <= 1'b0;
        program_fail <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      erase_suspended_flag   <= sec_pkg::FLAG_RESET;
      program_suspended_flag <= sec_pkg::FLAG_RESET;
    end else begin
      if (suspend_evt.erase_suspend) begin
        erase_suspended_flag <= 1'b1;
      end else if (suspend_evt.erase_resume) begin
        erase_suspended_flag <= 1'b0;
      end
      if (suspend_evt.program_suspend) begin
        program_suspended_flag <= 1'b1;
      end else if (suspend_evt.program_resume) begin
        program_suspended_flag <= 1'b0;
      end
    end
  end

  // One-time bits load from their non-volatile copies one cycle after reset
  // release, then only ever move towards one.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      nv_loaded                  <= 1'b0;
      factory_locked             <= sec_pkg::FLAG_RESET;
      scheme_select              <= sec_pkg::FLAG_RESET;
      otp_customer_lockdown_flag <= sec_pkg::FLAG_RESET;
      volatile_all_locked        <= 1'b0;
    end else if (!nv_loaded) begin
      nv_loaded                  <= 1'b1;
      factory_locked             <= factory_lock;
      scheme_select              <= nv_scheme_select;
      otp_customer_lockdown_flag <= nv_customer_lockdown;
      volatile_all_locked        <= nv_scheme_select;
    end else begin
      if (do_scheme) begin
        scheme_select <= 1'b1;
      end
      if (do_sec_wr) begin
        otp_customer_lockdown_flag <= 1'b1;
      end
      if (do_unlock && scheme_select) begin
        volatile_all_locked <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      write_enable_latch <= 1'b0;
    end else if (do_write_enable_cmd) begin
      write_enable_latch <= 1'b1;
    end else if (write_taken) begin
      write_enable_latch <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Serial readout
  // ----------------------------------------------------------------
  // Each byte is a fresh snapshot, so polling inside one frame sees live status
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_byte <= 8'h00;
      tx_cnt  <= sec_pkg::BIT_FIRST;
      so_out  <= 1'b0;
      so_oe   <= 1'b0;
    end else begin
      so_oe <= in_frame & (next_state == sec_pkg::ST_READ);
      if (first_byte && is_read) begin
        tx_byte <= status_now;
        tx_cnt  <= sec_pkg::BIT_FIRST;
      end else if (state == sec_pkg::ST_READ && sclk_fall) begin
        so_out <= tx_byte[7];
        tx_cnt <= tx_cnt + 3'h1;
        if (tx_cnt == sec_pkg::BIT_LAST) begin
          tx_byte <= status_now;
        end else begin
          tx_byte <= {tx_byte[6:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      security_status_register <= 8'h00;
    end else begin
      security_status_register <= status_now;
    end
  end

  // ----------------------------------------------------------------
  // Protection verdict
  // ----------------------------------------------------------------
  wire wp_low = ~wp_n_s2;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      protect <= '0;
    end else begin
      protect.block_enable     <= ~scheme_select;
      protect.sector_enable    <= scheme_select;
      protect.level_locked     <= ~scheme_select & status_write_disable & wp_low;
      protect.all_locked       <= scheme_select & (wp_low | volatile_all_locked);
      protect.array_deny       <= otp_mode;
      protect.otp_write_locked <= otp_customer_lockdown_flag;
    end
  end

endmodule // security_status_protect

// ===== spi_host_model.sv
// Holds a behavioural serial flash host that frames opcodes and reads status bytes.
// Assumes mode 0 on the link, driven off the core clock edges at a 64 ns serial period.
`timescale 1ns/100ps

module spi_host_model (
  // Core clock
  input  wire logic clk,
  // Link pins
  output logic      sclk,
  output logic      cs_n,
  output logic      si,
  input  wire logic so_out,
  // Captured readback
  output logic [7:0] rd_byte,
  output logic      rd_valid
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    rd_byte = 8'h00;
    rd_valid = 1'b0;
  end

  task automatic half();
    repeat (8) @(posedge clk);
  endtask

  // Opcode bits MSB first, then readback bytes; a short count gives an unaligned frame
  task automatic frame(input logic [7:0] op, input int nbits, input int nrd);
    logic [7:0] sh;
    sh = 8'h00;
    @(posedge clk) cs_n <= 1'b0;
    for (int i = 0; i < nbits; i++) begin
      si <= op[7-i];
      half();
      sclk <= 1'b1;
      half();
      sclk <= 1'b0;
    end
    for (int b = 0; b < nrd; b++) begin
      for (int i = 0; i < 8; i++) begin
        half();
        sclk <= 1'b1;
        if (i == 0) rd_valid <= 1'b0;
        sh = {sh[6:0], so_out};
        half();
        sclk <= 1'b0;
      end
      rd_byte <= sh;
      rd_valid <= 1'b1;
    end
    half();
    cs_n <= 1'b1;
    // Released line shows the inverse so a stale bit is never mistaken for data
    si <= ~si;
    rd_valid <= 1'b0;
    repeat (16) @(posedge clk);
  endtask
endmodule // spi_host_model

// ===== security_status_protect_checker.sv
// Holds the concurrent checks on the status register and protection verdict.
// Assumes it is bound to the block and sees only its ports.
`timescale 1ns/100ps

module security_status_protect_checker (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  rst,
  // Inputs
  input wire logic                  wp_n,
  input wire logic                  cs_n,
  input wire logic                  otp_mode,
  input wire logic                  status_write_disable,
  input wire sec_pkg::op_result_t   op_result,
  input wire sec_pkg::suspend_evt_t suspend_evt,
  // Outputs
  input wire logic [7:0]            security_status_register,
  input wire logic                  so_oe,
  input wire sec_pkg::protect_t     protect
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_erase_fail_set: assert property (
    op_result.done && op_result.is_erase && op_result.fail |-> ##2 security_status_register[6])
    else $error("erase failure not flagged");
  a_prog_fail_set: assert property (
    op_result.done && !op_result.is_erase && (op_result.fail || op_result.protected_hit)
    |-> ##2 security_status_register[5]) else $error("program failure not flagged");
  a_fail_clear: assert property (
    op_result.done && !op_result.fail && !op_result.protected_hit
    |-> ##2 security_status_register[6:5] == 2'h0) else $error("failure flags not cleared");
  a_erase_susp: assert property (
    suspend_evt.erase_suspend || suspend_evt.erase_resume
    |-> ##2 security_status_register[3] == $past(suspend_evt.erase_suspend, 2))
    else $error("erase suspend flag wrong");
  a_prog_susp: assert property (
    suspend_evt.program_suspend || suspend_evt.program_resume
    |-> ##2 security_status_register[2] == $past(suspend_evt.program_suspend, 2))
    else $error("program suspend flag wrong");
  a_reserved_zero: assert property (
    security_status_register[4] == 1'b0) else $error("reserved bit set");
  a_scheme_sticky: assert property (
    security_status_register[7] |=> security_status_register[7]) else $error("scheme cleared");
  a_one_scheme: assert property (
    !(protect.block_enable && protect.sector_enable)) else $error("two schemes active");
  a_wp_lock_all: assert property (
    protect.sector_enable [*4] ##0 !wp_n [*8] |-> protect.all_locked)
    else $error("low protect pin left sectors open");
  a_otp_deny: assert property (
    otp_mode [*4] |-> protect.array_deny) else $error("array open in otp mode");
  a_level_lock: assert property (
    (protect.block_enable && status_write_disable && !wp_n) [*8] |-> protect.level_locked)
    else $error("block levels not frozen");
  // Pin latency is three clocks, so four idle cycles are just enough for the release
  a_so_quiet: assert property (
    cs_n [*4] |-> !so_oe) else $error("serial output driven outside a frame");
endmodule // security_status_protect_checker

bind security_status_protect security_status_protect_checker i_security_status_protect_checker (
  .clk(clk), .rst(rst), .wp_n(wp_n), .cs_n(cs_n), .otp_mode(otp_mode),
  .status_write_disable(status_write_disable), .op_result(op_result),
  .suspend_evt(suspend_evt), .security_status_register(security_status_register),
  .so_oe(so_oe), .protect(protect));

// ===== security_status_protect_tb_top.sv
// Holds the self-checking bench: host model frames, sequencer pulses, queued status compares.
// Assumes default opcodes of the block and the host model in its own file.
`timescale 1ns/100ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin bad_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end

module security_status_protect_tb_top;
  logic clk, rst, sclk, cs_n, si, wp_n, so_out, so_oe, otp_mode, status_write_disable;
  logic factory_lock, nv_scheme_select, nv_customer_lockdown, write_enable_latch, rd_valid;
  logic [7:0] security_status_register, rd_byte, expv;
  sec_pkg::op_result_t   op_result;
  sec_pkg::suspend_evt_t suspend_evt;
  sec_pkg::protect_t     protect;
  logic [7:0] exp_q[$];
  logic [7:0] exp_pop;
  int bad_count, n_checks, seed, r;

  always #2 clk = ~clk;

  security_status_protect i_security_status_protect (.clk(clk), .rst(rst), .sclk(sclk),
    .cs_n(cs_n), .si(si), .wp_n(wp_n), .so_out(so_out), .so_oe(so_oe), .op_result(op_result),
    .suspend_evt(suspend_evt), .otp_mode(otp_mode), .status_write_disable(status_write_disable),
    .factory_lock(factory_lock), .nv_scheme_select(nv_scheme_select),
    .nv_customer_lockdown(nv_customer_lockdown), .protect(protect),
    .security_status_register(security_status_register),
    .write_enable_latch(write_enable_latch));

  spi_host_model i_spi_host_model (.clk(clk), .sclk(sclk), .cs_n(cs_n), .si(si),
    .so_out(so_out), .rd_byte(rd_byte), .rd_valid(rd_valid));

  // Each captured byte answers the oldest expectation
  // The note is popped once, so a mismatch cannot swallow the next expectation
  always @(posedge rd_valid) begin
    if (exp_q.size() == 0) begin
      `CHK(1'b1, 1'b0)
    end else begin
      exp_pop = exp_q.pop_front();
      `CHK(rd_byte, exp_pop)
    end
    `CHK(so_oe, 1'b1)
  end

  task automatic rd(input int nb);
    for (int i = 0; i < nb; i++) exp_q.push_back(expv);
    i_spi_host_model.frame(8'hA2, 8, nb);
  endtask

  task automatic cmd(input logic [7:0] op);
    i_spi_host_model.frame(8'hA1, 8, 0);
    i_spi_host_model.frame(op, 8, 0);
  endtask

  task automatic opdone(input logic e, input logic f, input logic p);
    @(posedge clk) op_result <= '{1'b1, e, f, p};
    @(posedge clk) op_result <= '0;
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #120000;
    bad_count++;
    end_of_test();
  end

  initial begin
    clk = 0; rst = 1; wp_n = 1; otp_mode = 0; status_write_disable = 0; factory_lock = 1;
    nv_scheme_select = 0; nv_customer_lockdown = 0; op_result = '0; suspend_evt = '0;
    bad_count = 0; n_checks = 0; seed = 42; expv = 8'h01;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    rd(1);
    // Block mode: status lock with a low pin freezes the levels, sectors stay open
    @(posedge clk) status_write_disable <= 1'b1;
    wp_n <= 1'b0;
    repeat (10) @(posedge clk);
    `CHK(protect.level_locked, 1'b1)
    `CHK(protect.block_enable, 1'b1)
    `CHK(protect.all_locked, 1'b0)
    wp_n <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK(protect.level_locked, 1'b0)
    status_write_disable <= 1'b0;
    $display("test 1 done");
    // Refused: no write enable, then an unaligned frame
    i_spi_host_model.frame(8'hA4, 8, 0);
    rd(1);
    i_spi_host_model.frame(8'hA1, 8, 0);
    `CHK(write_enable_latch, 1'b1)
    i_spi_host_model.frame(8'hA4, 7, 0);
    rd(1);
    i_spi_host_model.frame(8'hA4, 8, 0);
    `CHK(write_enable_latch, 1'b0)
    expv = 8'h81;
    rd(1);
    $display("test 2 done");
    cmd(8'hA3);
    expv = 8'h83;
    rd(2);
    `CHK(protect.otp_write_locked, 1'b1)
    $display("test 3 done");
    // Power-up with scheme already chosen: everything locked until unlock
    @(posedge clk) rst <= 1'b1;
    factory_lock <= 1'b0;
    nv_scheme_select <= 1'b1;
    nv_customer_lockdown <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK(protect.all_locked, 1'b1)
    expv = 8'h82;
    rd(1);
    cmd(8'hA5);
    `CHK(protect.all_locked, 1'b0)
    @(posedge clk) wp_n <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK(protect.all_locked, 1'b1)
    $display("test 4 done");
    for (int k = 0; k < 12; k++) begin
      r = $random(seed);
      opdone(1'b0, 1'b0, 1'b0);
      opdone(r[0], r[1], r[2] & ~r[0]);
      expv[6:5] = r[0] ? {r[1], 1'b0} : {1'b0, r[1] | r[2]};
      @(posedge clk) suspend_evt <= sec_pkg::suspend_evt_t'(4'h1 << r[4:3]);
      wp_n <= r[7];
      otp_mode <= r[6];
      status_write_disable <= r[5];
      @(posedge clk) suspend_evt <= '0;
      expv[r[4] ? 3 : 2] = r[3];
      rd(1);
    end
    $display("test 5 done");
    end_of_test();
  end
endmodule // security_status_protect_tb_top
